/* File: dv/irfc_front_model.sv */
`default_nettype none
module irfc_front_model
    import irfc_pkg::*;
(
    input  wire logic  sys_clk,
    output irfc_byte_t rx_byte,
    output logic       rx_byte_vld,
    output logic       rx_bof,
    output logic       rx_eof,
    output logic       rx_crc_bad,
    output logic       tx_idle
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // Receive front end and transmitter idle
    // ********
    initial begin
        {rx_byte_vld, rx_bof, rx_eof, rx_crc_bad, tx_idle} = 5'h01;
        rx_byte = 8'h00;
    end
    task automatic frame(input irfc_byte_t b[$], input logic bad);
        @(posedge sys_clk) rx_bof <= 1'b1;
        foreach (b[i]) @(posedge sys_clk) begin
            {rx_bof, rx_byte_vld, rx_byte} <= {2'b01, b[i]};
            rx_eof <= (i == b.size() - 1);
        end
        @(posedge sys_clk) begin
            {rx_byte_vld, rx_eof, rx_crc_bad} <= {2'b00, bad};
            rx_byte <= ~rx_byte;
        end
        @(posedge sys_clk) rx_crc_bad <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic set_idle(input logic v);
        @(posedge sys_clk) tx_idle <= v;
    endtask
endmodule
`default_nettype wire

/* File: dv/test_irfc_fifo_ctrl.sv */
`default_nettype none
module test_irfc_fifo_ctrl import irfc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    irfc_byte_t  reg_wdata = 8'h00, reg_rdata, tx_byte, rx_byte, d;
    logic        rx_byte_vld, rx_bof, rx_eof, rx_crc_bad, tx_idle, dma_mode;
    logic        tx_byte_vld, rx_trig, rx_dma_req, tx_dma_req, fifo_enabled;
    logic        fir_bad_symbol = 1'b0, mir_bit_vld = 1'b0, mir_bit = 1'b0;
    logic        consumer_ir_pulse = 1'b0, tx_req = 1'b0;
    int          mismatches = 0, comparisons = 0;
    logic [15:0] lfsr = 16'h4ba7;
    irfc_byte_t  q[$];
    // ********
    // Harness
    // ********
    always #5 sys_clk = ~sys_clk;
    irfc_fifo_ctrl #(.SF_DEPTH(8)) dut (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .rx_byte_vld, .rx_byte, .rx_bof, .rx_eof, .rx_crc_bad,
        .fir_bad_symbol, .mir_bit_vld, .mir_bit,
        .consumer_ir_pulse, .tx_req, .tx_idle, .tx_byte, .tx_byte_vld,
        .rx_trig, .rx_dma_req, .tx_dma_req, .dma_mode, .fifo_enabled);
    irfc_front_model fe (.sys_clk, .rx_byte, .rx_byte_vld, .rx_bof, .rx_eof,
        .rx_crc_bad, .tx_idle);
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic mk(input int n);
        q = {};
        repeat (n) begin
            lfsr = nxt(lfsr);
            q.push_back(lfsr[7:0]);
        end
    endtask
    task automatic wr(input logic [3:0] a, input irfc_byte_t v);
        @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input string n, input irfc_byte_t e, input irfc_byte_t s);
        comparisons++;
        if (e !== s) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stat(input irfc_byte_t e);
        rd(4'h5);
        chk("line_status", e, d);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        mismatches++;
        stop_test;
    end
    // ********
    // Tests
    // ********
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        stat(8'h83);
        wr(4'h2, 8'h09);
        wr(4'h8, 8'h04);
        stat(8'h83);
        chk("fifo_enabled", 8'h01, fifo_enabled);
        chk("dma_mode", 8'h01, dma_mode);
        $display("setup test done");
        mk(3);
        fe.frame(q, 1'b1);
        stat(8'h84);
        foreach (q[i]) begin
            rd(4'h0);
            chk("rx_data", q[i], d);
        end
        stat(8'ha1);
        stat(8'h81);
        rd(4'h4);
        chk("frame_len", 8'h03, d);
        stat(8'h83);
        wr(4'h0, lfsr[15:8]);
        stat(8'h03);
        wr(4'h2, 8'h0d);
        stat(8'h83);
        $display("frame test done");
        mk(2);
        fe.frame(q, 1'b0);
        wr(4'h2, 8'h0b);
        stat(8'h83);
        rd(4'h4);
        chk("frame_len", 8'h00, d);
        fe.frame(q, 1'b0);
        wr(4'h2, 8'h00);
        wr(4'h2, 8'h49);
        rd(4'h4);
        stat(8'h83);
        $display("flush test done");
        mk(4);
        fe.frame(q, 1'b0);
        chk("rx_dma_req", 8'h01, rx_dma_req);
        chk("tx_dma_req", 8'h01, tx_dma_req);
        chk("rx_trig", 8'h00, rx_trig);
        rd(4'h0);
        rd(4'h5);
        chk("rx_dma_req", 8'h00, rx_dma_req);
        wr(4'h3, 8'h80);
        wr(4'h2, 8'h69);
        wr(4'h3, 8'h00);
        fe.frame(q, 1'b0);
        chk("rx_dma_req", 8'h00, rx_dma_req);
        $display("trigger test done");
        wr(4'h2, 8'h07);
        stat(8'h83);
        chk("rx_trig", 8'h00, rx_trig);
        @(posedge sys_clk) fir_bad_symbol <= 1'b1;
        @(posedge sys_clk) fir_bad_symbol <= 1'b0;
        stat(8'h8b);
        wr(4'h8, 8'h03);
        @(posedge sys_clk) {mir_bit_vld, mir_bit} <= 2'b11;
        repeat (6) @(posedge sys_clk);
        mir_bit_vld <= 1'b0;
        stat(8'h83);
        @(posedge sys_clk) mir_bit_vld <= 1'b1;
        @(posedge sys_clk) mir_bit_vld <= 1'b0;
        stat(8'h8b);
        wr(4'h8, 8'h05);
        fe.set_idle(1'b0);
        stat(8'h81);
        @(posedge sys_clk) consumer_ir_pulse <= 1'b1;
        @(posedge sys_clk) consumer_ir_pulse <= 1'b0;
        stat(8'h83);
        stat(8'h81);
        wr(4'h8, 8'h04);
        stat(8'h03);
        fe.set_idle(1'b1);
        $display("status test done");
        mk(1);
        wr(4'h0, q[0]);
        @(posedge sys_clk) tx_req <= 1'b1;
        @(posedge sys_clk) tx_req <= 1'b0;
        #1 chk("tx_byte_vld", 8'h01, tx_byte_vld);
        chk("tx_byte", q[0], tx_byte);
        wr(4'h0, lfsr[15:8]);
        wr(4'h2, 8'h05);
        chk("tx_byte", q[0], tx_byte);
        wr(4'h6, 8'h02);
        wr(4'h7, 8'h00);
        mk(4);
        fe.frame(q, 1'b0);
        stat(8'h92);
        chk("rx_trig", 8'h01, rx_trig);
        mk(1);
        repeat (8) fe.frame(q, 1'b0);
        stat(8'hc0);
        $display("limit test done");
        stop_test;
    end
endmodule
`default_nettype wire

/* File: rtl/irfc_defines.svh */
`ifndef IRFC_DEFINES_SVH
`define IRFC_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define IRFC_ADDR_DATA        4'h0
`define IRFC_ADDR_FIFO_CTRL   4'h2
`define IRFC_ADDR_LINE_CTRL   4'h3
`define IRFC_ADDR_FRAME_STAT  4'h4
`define IRFC_ADDR_LINE_STATUS 4'h5
`define IRFC_ADDR_MAXLEN_LO   4'h6
`define IRFC_ADDR_MAXLEN_HI   4'h7
`define IRFC_ADDR_MODE_DEF    4'h8

// ****************************************
// Field positions
// ****************************************
`define IRFC_FC_EN        0
`define IRFC_FC_RX_RST    1
`define IRFC_FC_TX_RST    2
`define IRFC_FC_DMA       3
`define IRFC_FC_DEPTH     5
`define IRFC_FC_TRIG_LO   6
`define IRFC_FC_TRIG_HI   7
`define IRFC_LC_BANK      7
`define IRFC_MD_MODE_HI   2
`define IRFC_LS_RX_EMPTY  0
`define IRFC_LS_SF_EMPTY  1
`define IRFC_LS_CRC       2
`define IRFC_LS_PHY       3
`define IRFC_LS_TOO_LONG  4
`define IRFC_LS_LAST_READ 5
`define IRFC_LS_SF_FULL   6
`define IRFC_LS_TX_EMPTY  7

// ****************************************
// Modes, levels, reset values
// ****************************************
`define IRFC_MODE_MIR     3'h3
`define IRFC_MODE_FIR     3'h4
`define IRFC_MODE_CIR     3'h5
`define IRFC_DEPTH_LARGE  7'h40
`define IRFC_DEPTH_SMALL  7'h10
`define IRFC_DEPTH_OFF    7'h01
`define IRFC_TRIG_00      7'h01
`define IRFC_TRIG_01_S    7'h04
`define IRFC_TRIG_10_S    7'h08
`define IRFC_TRIG_11_S    7'h0e
`define IRFC_TRIG_01_L    7'h10
`define IRFC_TRIG_10_L    7'h20
`define IRFC_TRIG_11_L    7'h38
`define IRFC_ABORT_ONES   3'h7
`define IRFC_MAXLEN_RESET 16'h0800
`define IRFC_BYTE_RESET   8'h00
`define IRFC_MODE_RESET   3'h0

`endif

/* File: rtl/irfc_fifo.sv */
`include "irfc_defines.svh"
`default_nettype none
module irfc_fifo
    import irfc_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 64,
    localparam int AW   = $clog2(DEPTH),
    localparam int CW   = AW + 1
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    input  wire logic          flush,
    input  wire logic [CW-1:0] limit,
    input  wire logic          push,
    input  wire logic [W-1:0]  din,
    input  wire logic          pop,
    output logic      [W-1:0]  dout,
    output logic      [CW-1:0] count,
    output logic               empty,
    output logic               full
);
    // ****************************************
    // Storage and pointers
    // ****************************************
    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic          do_push;
    logic          do_pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("irfc_fifo: DEPTH must be a power of two of at least 2");
    end

    assign do_push = push && !full;
    assign do_pop  = pop && !empty;
    assign dout    = mem_q[rd_ptr_q];
    assign count   = count_q;
    assign empty   = (count_q == '0);
    assign full    = (count_q >= limit);

    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= din;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + AW'(1);
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + CW'(1);
            end else if (do_pop && !do_push) begin
                count_q <= count_q - CW'(1);
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    fifo_flush_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        flush |=> empty && !full) else $error("FIFO not empty after flush");
    fifo_count_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (do_push && !do_pop && !flush) |=> count == $past(count) + CW'(1))
        else $error("FIFO count did not rise on push");
endmodule
`default_nettype wire

/* File: rtl/irfc_fifo_ctrl.sv */
`include "irfc_defines.svh"
`default_nettype none
module irfc_fifo_ctrl
    import irfc_pkg::*;
#(
    parameter int SF_DEPTH = 8
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic [3:0] reg_addr,
    input  wire irfc_byte_t reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output irfc_byte_t      reg_rdata,
    input  wire logic       rx_byte_vld,
    input  wire irfc_byte_t rx_byte,
    input  wire logic       rx_bof,
    input  wire logic       rx_eof,
    input  wire logic       rx_crc_bad,
    input  wire logic       fir_bad_symbol,
    input  wire logic       mir_bit_vld,
    input  wire logic       mir_bit,
    input  wire logic       consumer_ir_pulse,
    input  wire logic       tx_req,
    input  wire logic       tx_idle,
    output irfc_byte_t      tx_byte,
    output logic            tx_byte_vld,
    output logic            rx_trig,
    output logic            rx_dma_req,
    output logic            tx_dma_req,
    output logic            dma_mode,
    output logic            fifo_enabled
);
    localparam int SFCW = $clog2(SF_DEPTH) + 1;

    if (SF_DEPTH < 2 || (1 << (SFCW - 1)) != SF_DEPTH) begin : g_bad_sf_depth
        $error("irfc_fifo_ctrl: SF_DEPTH must be a power of two of at least 2");
    end

    // ****************************************
    // Declarations
    // ****************************************
    logic            fc_en_q;
    logic            fc_dma_q;
    logic            fc_depth_q;
    logic [1:0]      fc_trig_q;
    logic            rx_flush_q;
    logic            tx_flush_q;
    irfc_byte_t      line_ctrl_q;
    logic [15:0]     maxlen_q;
    irfc_byte_t      mode_def_q;
    irfc_rx_state_e  rx_state_q;
    logic [15:0]     rx_len_q;
    logic [2:0]      ones_q;
    logic            crc_q;
    logic            phy_q;
    logic            long_q;
    logic            last_q;
    logic            cir_q;
    irfc_byte_t      rdata_q;
    irfc_byte_t      tx_byte_q;
    logic            tx_vld_q;
    logic            rx_trig_q;
    logic            rx_dma_q;
    logic            tx_dma_q;
    logic            wr_fc;
    logic            wr_data;
    logic            rd_data;
    logic            rd_lsr;
    logic            rd_fstat;
    logic [2:0]      mode;
    logic            is_mir;
    logic            is_fir;
    logic            is_cir;
    logic            framed;
    logic [6:0]      limit;
    logic [6:0]      trig_lvl;
    logic            rx_push;
    logic            rx_last;
    logic            long_set;
    logic [8:0]      rx_dout;
    logic [6:0]      rx_count;
    logic            rx_empty;
    logic            rx_full;
    irfc_byte_t      tx_dout;
    logic [6:0]      tx_count;
    logic            tx_empty;
    logic            tx_full;
    logic            tx_pop;
    irfc_byte_t      sf_dout;
    logic            sf_empty;
    logic            sf_full;
    logic            crc_set;
    logic            phy_set;
    logic            last_set;
    logic            cir_set;
    logic            tx_all_empty;
    irfc_byte_t      lsr_val;
    irfc_byte_t      rd_mux;

    // ****************************************
    // Register decode
    // ****************************************
    assign wr_fc    = reg_wr && reg_addr == `IRFC_ADDR_FIFO_CTRL;
    assign wr_data  = reg_wr && reg_addr == `IRFC_ADDR_DATA;
    assign rd_data  = reg_rd && reg_addr == `IRFC_ADDR_DATA;
    assign rd_lsr   = reg_rd && reg_addr == `IRFC_ADDR_LINE_STATUS;
    assign rd_fstat = reg_rd && reg_addr == `IRFC_ADDR_FRAME_STAT;

    assign mode   = mode_def_q[`IRFC_MD_MODE_HI:0];
    assign is_mir = (mode == `IRFC_MODE_MIR);
    assign is_fir = (mode == `IRFC_MODE_FIR);
    assign is_cir = (mode == `IRFC_MODE_CIR);
    assign framed = is_mir || is_fir;

    // ****************************************
    // FIFO control register
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fc_en_q    <= 1'b0;
            fc_dma_q   <= 1'b0;
            fc_depth_q <= 1'b0;
            fc_trig_q  <= 2'h0;
        end else if (wr_fc) begin
            fc_en_q   <= reg_wdata[`IRFC_FC_EN];
            fc_dma_q  <= reg_wdata[`IRFC_FC_DMA];
            fc_trig_q <= reg_wdata[`IRFC_FC_TRIG_HI:`IRFC_FC_TRIG_LO];
            if (line_ctrl_q[`IRFC_LC_BANK]) begin
                fc_depth_q <= reg_wdata[`IRFC_FC_DEPTH];
            end
        end
    end

    // Self-clearing flush pulses
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rx_flush_q <= 1'b0;
            tx_flush_q <= 1'b0;
        end else begin
            rx_flush_q <= wr_fc && (reg_wdata[`IRFC_FC_RX_RST]
                          || reg_wdata[`IRFC_FC_EN] != fc_en_q);
            tx_flush_q <= wr_fc && (reg_wdata[`IRFC_FC_TX_RST]
                          || reg_wdata[`IRFC_FC_EN] != fc_en_q);
        end
    end

    // ****************************************
    // Other software registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            line_ctrl_q <= `IRFC_BYTE_RESET;
            maxlen_q    <= `IRFC_MAXLEN_RESET;
            mode_def_q  <= {5'h00, `IRFC_MODE_RESET};
        end else if (reg_wr) begin
            unique case (reg_addr)
                `IRFC_ADDR_LINE_CTRL:  line_ctrl_q    <= reg_wdata;
                `IRFC_ADDR_MAXLEN_LO:  maxlen_q[7:0]  <= reg_wdata;
                `IRFC_ADDR_MAXLEN_HI:  maxlen_q[15:8] <= reg_wdata;
                `IRFC_ADDR_MODE_DEF:   mode_def_q     <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // Depth and trigger level
    // ****************************************
    always_comb begin
        if (!fc_en_q) begin
            limit = `IRFC_DEPTH_OFF;
        end else if (fc_depth_q) begin
            limit = `IRFC_DEPTH_LARGE;
        end else begin
            limit = `IRFC_DEPTH_SMALL;
        end
    end

    always_comb begin
        unique case (fc_trig_q)
            2'h0: trig_lvl = `IRFC_TRIG_00;
            2'h1: trig_lvl = fc_depth_q ? `IRFC_TRIG_01_L : `IRFC_TRIG_01_S;
            2'h2: trig_lvl = fc_depth_q ? `IRFC_TRIG_10_L : `IRFC_TRIG_10_S;
            2'h3: trig_lvl = fc_depth_q ? `IRFC_TRIG_11_L : `IRFC_TRIG_11_S;
        endcase
    end

    // ****************************************
    // Receive framing
    // ****************************************
    always_comb begin
        rx_push  = 1'b0;
        rx_last  = 1'b0;
        long_set = 1'b0;
        if (rx_byte_vld) begin
            if (is_cir) begin
                rx_push = 1'b1;
            end else if (framed && rx_state_q == RX_FRAME) begin
                if (rx_len_q >= maxlen_q) begin
                    long_set = 1'b1;
                end else begin
                    rx_push = 1'b1;
                    rx_last = rx_eof;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || !framed) begin
            rx_state_q <= RX_IDLE;
            rx_len_q   <= 16'h0000;
        end else begin
            unique case (rx_state_q)
                RX_IDLE: begin
                    if (rx_bof) begin
                        rx_state_q <= RX_FRAME;
                        rx_len_q   <= 16'h0000;
                    end
                end
                RX_FRAME: begin
                    if (rx_bof) begin
                        rx_len_q <= 16'h0000;
                    end else if (long_set) begin
                        rx_state_q <= RX_DISCARD;
                    end else if (rx_push && rx_last) begin
                        rx_state_q <= RX_IDLE;
                    end else if (rx_push) begin
                        rx_len_q <= rx_len_q + 16'h0001;
                    end
                end
                RX_DISCARD: begin
                    if (rx_bof) begin
                        rx_state_q <= RX_FRAME;
                        rx_len_q   <= 16'h0000;
                    end
                end
            endcase
        end
    end

    // Consecutive ones for the MIR abort pattern
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !is_mir) begin
            ones_q <= 3'h0;
        end else if (mir_bit_vld) begin
            if (!mir_bit) begin
                ones_q <= 3'h0;
            end else if (ones_q != `IRFC_ABORT_ONES) begin
                ones_q <= ones_q + 3'h1;
            end
        end
    end

    // ****************************************
    // FIFOs
    // ****************************************
    irfc_fifo #(.W(9), .DEPTH(64)) u_rx_fifo (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .flush   (rx_flush_q),
        .limit   (limit),
        .push    (rx_push),
        .din     ({rx_last, rx_byte}),
        .pop     (rd_data),
        .dout    (rx_dout),
        .count   (rx_count),
        .empty   (rx_empty),
        .full    (rx_full)
    );

    irfc_fifo #(.W(8), .DEPTH(64)) u_tx_fifo (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .flush   (tx_flush_q),
        .limit   (limit),
        .push    (wr_data),
        .din     (reg_wdata),
        .pop     (tx_pop),
        .dout    (tx_dout),
        .count   (tx_count),
        .empty   (tx_empty),
        .full    (tx_full)
    );

    irfc_fifo #(.W(8), .DEPTH(SF_DEPTH)) u_sf_fifo (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .flush   (rx_flush_q),
        .limit   (SFCW'(SF_DEPTH)),
        .push    (rx_push && rx_last),
        .din     (rx_len_q[7:0] + 8'h01),
        .pop     (rd_fstat),
        .dout    (sf_dout),
        .count   (),
        .empty   (sf_empty),
        .full    (sf_full)
    );

    // ****************************************
    // Transmit hand-off
    // ****************************************
    assign tx_pop = tx_req && !tx_empty;

    // Holding register survives FIFO resets
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            tx_byte_q <= `IRFC_BYTE_RESET;
        end else if (tx_pop) begin
            tx_byte_q <= tx_dout;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            tx_vld_q <= 1'b0;
        end else begin
            tx_vld_q <= tx_pop;
        end
    end

    // ****************************************
    // Transfer requests
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rx_trig_q <= 1'b0;
            rx_dma_q  <= 1'b0;
            tx_dma_q  <= 1'b0;
        end else begin
            rx_trig_q <= !fc_dma_q && rx_count >= trig_lvl;
            rx_dma_q  <= fc_dma_q && rx_count >= trig_lvl;
            tx_dma_q  <= fc_dma_q && !tx_full;
        end
    end

    // ****************************************
    // Sticky status flags
    // ****************************************
    assign crc_set  = framed && rx_crc_bad;
    assign phy_set  = (is_fir && fir_bad_symbol) || (is_mir && mir_bit_vld && mir_bit
                      && ones_q >= `IRFC_ABORT_ONES - 3'h1);
    assign last_set = rd_data && !rx_empty && rx_dout[8];
    assign cir_set  = is_cir && consumer_ir_pulse;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            crc_q  <= 1'b0;
            phy_q  <= 1'b0;
            long_q <= 1'b0;
            last_q <= 1'b0;
            cir_q  <= 1'b0;
        end else begin
            crc_q  <= crc_set || (crc_q && !rd_lsr);
            phy_q  <= phy_set || (phy_q && !rd_lsr);
            long_q <= long_set || (long_q && !rd_lsr);
            last_q <= last_set || (last_q && !rd_lsr);
            cir_q  <= cir_set || (cir_q && !rd_lsr);
        end
    end

    // ****************************************
    // Status layout and read data
    // ****************************************
    assign tx_all_empty = tx_empty && tx_idle && !tx_vld_q;

    always_comb begin
        if (is_cir) begin
            lsr_val = {tx_empty, 5'h00, cir_q, rx_empty};
        end else begin
            lsr_val = {tx_all_empty, sf_full, last_q, long_q,
                       phy_q, crc_q, sf_empty, rx_empty};
        end
    end

    always_comb begin
        unique case (reg_addr)
            `IRFC_ADDR_DATA:        rd_mux = rx_empty ? `IRFC_BYTE_RESET : rx_dout[7:0];
            `IRFC_ADDR_LINE_CTRL:   rd_mux = line_ctrl_q;
            `IRFC_ADDR_FRAME_STAT:  rd_mux = sf_empty ? `IRFC_BYTE_RESET : sf_dout;
            `IRFC_ADDR_LINE_STATUS: rd_mux = lsr_val;
            `IRFC_ADDR_MAXLEN_LO:   rd_mux = maxlen_q[7:0];
            `IRFC_ADDR_MAXLEN_HI:   rd_mux = maxlen_q[15:8];
            `IRFC_ADDR_MODE_DEF:    rd_mux = mode_def_q;
            default:                rd_mux = `IRFC_BYTE_RESET;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdata_q <= `IRFC_BYTE_RESET;
        end else begin
            rdata_q <= reg_rd ? rd_mux : `IRFC_BYTE_RESET;
        end
    end

    assign reg_rdata    = rdata_q;
    assign tx_byte      = tx_byte_q;
    assign tx_byte_vld  = tx_vld_q;
    assign rx_trig      = rx_trig_q;
    assign rx_dma_req   = rx_dma_q;
    assign tx_dma_req   = tx_dma_q;
    assign dma_mode     = fc_dma_q;
    assign fifo_enabled = fc_en_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_lsr_read;
        reg_rd && reg_addr == `IRFC_ADDR_LINE_STATUS;
    endsequence

    sequence s_fc_write(int bitpos);
        wr_fc && reg_wdata[bitpos];
    endsequence

    rx_reset_flush_a: assert property (s_fc_write(`IRFC_FC_RX_RST) |-> ##2 rx_count == 7'h00)
        else $error("Receive FIFO not cleared by reset bit");
    tx_reset_flush_a: assert property (s_fc_write(`IRFC_FC_TX_RST) |-> ##2 tx_count == 7'h00)
        else $error("Transmit FIFO not cleared by reset bit");
    enable_change_a: assert property ((wr_fc && reg_wdata[`IRFC_FC_EN] != fc_en_q)
        |-> ##2 (rx_empty && tx_empty)) else $error("FIFOs kept data on enable change");
    depth_lock_a: assert property ((wr_fc && !line_ctrl_q[`IRFC_LC_BANK])
        |=> $stable(fc_depth_q)) else $error("Depth changed without bank access");
    crc_clear_a: assert property ((s_lsr_read ##0 !crc_set) |=> !crc_q)
        else $error("CRC flag survived status read");
    crc_report_a: assert property ((crc_set && !is_cir) |=> crc_q)
        else $error("CRC flag not latched");
    rx_empty_bit_a: assert property (s_lsr_read |=> reg_rdata[`IRFC_LS_RX_EMPTY]
        == $past(rx_empty)) else $error("Receive empty bit wrong");
    cir_zero_a: assert property ((s_lsr_read ##0 is_cir) |=> reg_rdata[6:2] == 5'h00)
        else $error("Consumer-IR status middle bits not zero");
    too_long_a: assert property (long_set |=> (long_q && rx_state_q != RX_FRAME))
        else $error("Over-length frame not flagged and discarded");
    tx_empty_bit_a: assert property ((s_lsr_read ##0 (!is_cir && !tx_idle))
        |=> !reg_rdata[`IRFC_LS_TX_EMPTY]) else $error("Transmitter empty while busy");
    dma_req_a: assert property (fc_dma_q && rx_count >= trig_lvl && !rx_flush_q
        |=> rx_dma_req) else $error("Receive DMA request missing at trigger");
    depth_limit_a: assert property ((fc_en_q && !fc_depth_q && rx_count == `IRFC_DEPTH_SMALL)
        |-> rx_full) else $error("Small receive FIFO not full at 16");
endmodule
`default_nettype wire

/* File: rtl/irfc_pkg.sv */
`default_nettype none
package irfc_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_DISCARD} irfc_rx_state_e;
    typedef logic [7:0] irfc_byte_t;
endpackage
`default_nettype wire
